//--- hdl/ppgab_core.sv
// Purpose: averaging, burst sequencing, settling delay and presence
//          compare with its register file and interrupt
// Assumes: one i_conv result answers each o_adc_start
// Notes:   all state but the check helpers is one struct, filled in one comb process
// Summary of operation
// - average 2^code conversions per slot, then push
// - burst mode uses average code as burst length
// - in burst, clamp average code to largest fitting value
// - no fitting code at all disables burst
// - fit limit from rate and burst table
// - settle delay between emitter on and integration
// - single bit selects filter type a or b
// - burst repeat rate from two-bit code
// - burst off runs one cycle per sample period
// - burst on: group, push average, await repeat
// - too slow rate clears burst enable itself
// - one cycle is the ordered slot sequence
// - LED1 top byte at threshold raises presence
// - threshold all ones fires only on a top byte of all ones
// - spike replace enable bit drives function on
// - unsupported rate code stored as highest supported
// - average and rate codes share one register
//
// Our own choice: strobed register access.
`timescale 1ns/100ps
module ppgab_core #(
	parameter int TICK_DIV = ppgab_pkg::TICK_CYC
) (
	input  wire logic                  i_sys_clk,
	input  wire logic                  i_sys_rst,
	input  wire ppgab_pkg::ppgab_bus_s  i_bus,
	output logic [7:0]                 o_rdata,
	input  wire ppgab_pkg::ppgab_conv_s i_conv,
	output logic                       o_led_on,
	output logic                       o_adc_start,
	output logic [2:0]                 o_slot,
	output ppgab_pkg::ppgab_fifo_s      o_fifo,
	output ppgab_pkg::ppgab_cfg_s       o_cfg,
	output logic                       o_prox_mode,
	output logic                       o_irq
);
	import ppgab_pkg::*;

	// Time base divider must fit its counter
	if (TICK_DIV < 2 || TICK_DIV > 65535) begin : g_chk
		$error("TICK_DIV out of range");
	end

	// Whole module state, check helpers apart
	typedef struct packed {
		ppgab_expo_s                      expo;   // Exposure setup
		ppgab_rate_s                      rate;   // Rate and average
		ppgab_timing_s                    tim;    // Timing and burst
		logic [7:0]                       thr;    // Presence threshold
		ppgab_bias_s                      bias;   // Detector bias
		ppgab_spike_s                     spk;    // Spike replace
		logic [1:0]                       istat;  // Sticky events
		logic [1:0]                       imask;  // Event mask
		logic                             prox;   // Proximity mode
		logic [7:0]                       rdata;  // Read answer
		logic [15:0]                      tdiv;   // Tick divider
		logic [12:0]                      scnt;   // Sample period
		logic [12:0]                      bcnt;   // Burst period
		logic                             bact;   // Burst running
		ppgab_fsm_e                       fsm;    // Sequencer
		logic [2:0]                       slot;   // Current slot
		logic [9:0]                       cnt;    // Settle count
		logic [6:0]                       grp;    // Group position
		logic [SLOTS-1:0][ACC_W-1:0]      acc;    // Slot sums
		logic                             led;    // Emitter on
		logic                             adc;    // Start pulse
		ppgab_fifo_s                      fifo;   // Pushed result
	} ppgab_state_s;

	ppgab_state_s     st;         // Registered state
	ppgab_state_s     next_st;    // Next state
	logic [3:0]       lut;        // Fit limit, all ones when none
	logic [2:0]       eff_avg;    // Average code in use
	logic [2:0]       nslot;      // Slots per cycle
	logic             tick;       // Time base tick
	logic             smp_wrap;   // Sample period end
	logic             bwrap;      // Burst period end
	logic             grp_last;   // Last member of group
	logic [ACC_W-1:0] sum;        // Slot sum with new result
	logic [9:0]       settle_hcnt;// Cycles spent settling
	logic [1:0]       settle_cd;  // Settle code in use

	// Settling cycles, rounded up
	function automatic logic [9:0] settle_cyc(input logic [1:0] c);
		settle_cyc = 10'((SETTLE_NS[c] * SYS_CLK_MHZ + 999) / 1000);
	endfunction

	// fit limit table
	// Largest average code per rate, nibble per burst rate
	function automatic logic [3:0] avg_lut(input logic [4:0] sr, input logic [1:0] br);
		logic [15:0] row;
		case (sr)
			5'h00, 5'h06, 5'h0c: row = 16'hfff1;
			5'h01, 5'h07, 5'h0d: row = 16'hff02;
			5'h02, 5'h03, 5'h08, 5'h09: row = 16'hff13;
			5'h04: row = 16'hf024;
			5'h05: row = 16'hf135;
			5'h0b: row = 16'hfff0;
			5'h0e: row = 16'hf013;
			5'h0f: row = 16'hf124;
			5'h10: row = 16'hf235;
			5'h11: row = 16'h0346;
			5'h12: row = 16'h1457;
			5'h13: row = 16'h2567;
			default: row = 16'hffff;
		endcase
		avg_lut = row[{br, 2'h0} +: 4];
	endfunction

	// Nominal rate of a code, reserved codes rank highest
	function automatic logic [12:0] sps_of(input logic [4:0] c);
		case (c)
			5'h00, 5'h06: sps_of = 13'h019;
			5'h01, 5'h07: sps_of = 13'h032;
			5'h02, 5'h08: sps_of = 13'h054;
			5'h03, 5'h09: sps_of = 13'h064;
			5'h04: sps_of = 13'h0c8;
			5'h05: sps_of = 13'h190;
			default: sps_of = (c < 5'h14) ? 13'h1000 >> (5'h13 - c) : 13'h1fff;
		endcase
	endfunction

	// Slots per cycle, kept within 1 to 6
	function automatic logic [2:0] slots_of(input logic [2:0] n);
		slots_of = (n == 3'h0) ? 3'h1 : ((n > 3'h6) ? 3'h6 : n);
	endfunction

	// Highest code the exposure setup supports
	function automatic logic [4:0] max_code(input logic n2, input logic [2:0] ne,
			input logic [1:0] t);
		logic [19:0] row;
		if (n2) begin
			case (ne)
				3'h1: row = {4{5'h09}};
				3'h2: row = {5'h08, 5'h08, 5'h08, 5'h09};
				3'h3: row = {4{5'h07}};
				default: row = {4{5'h06}};
			endcase
		end else begin
			case (ne)
				3'h1: row = {5'h11, 5'h12, 5'h12, 5'h13};
				3'h2: row = {5'h10, 5'h11, 5'h11, 5'h12};
				3'h3: row = {5'h10, 5'h10, 5'h11, 5'h11};
				3'h4: row = {5'h05, 5'h10, 5'h10, 5'h11};
				3'h5: row = {5'h0f, 5'h10, 5'h10, 5'h10};
				default: row = {5'h0f, 5'h05, 5'h10, 5'h10};
			endcase
		end
		max_code = row[t * 5 +: 5];
	endfunction

	// Decodes shared by the sequencer and its checks
	always_comb begin
		lut = avg_lut(st.rate.sr, st.tim.brate);
		nslot = slots_of(st.expo.nexp);
		eff_avg = (st.tim.ben && lut != LUT_DIS && st.rate.avg > lut[2:0]) ? lut[2:0]
			: st.rate.avg;
		tick = st.tdiv == 16'(TICK_DIV - 1);
		smp_wrap = tick && st.scnt >= smp_ticks(st.rate.sr) - 13'h1;
		bwrap = tick && st.bcnt >= burst_ticks(st.tim.brate) - 13'h1;
		// Past the end too, so a lowered code never strands a group
		grp_last = st.grp >= 7'((8'h01 << eff_avg) - 8'h01);
		sum = st.acc[st.slot] + ACC_W'(i_conv.data);
	end

	// Next state
	always_comb begin
		logic [1:0] ev;
		logic [1:0] w1c;
		logic       go;
		logic [4:0] mc;
		ev = 2'h0;
		w1c = 2'h0;
		go = 1'b0;
		mc = 5'h00;
		next_st = st;
		next_st.adc = 1'b0;
		next_st.fifo.valid = 1'b0;
		next_st.rdata = 8'h00;
		// Time base and period counters
		next_st.tdiv = tick ? 16'h0 : st.tdiv + 16'h1;
		if (smp_wrap) begin
			next_st.scnt = 13'h0;
		end else if (tick) begin
			next_st.scnt = st.scnt + 13'h1;
		end
		if (bwrap) begin
			next_st.bcnt = 13'h0;
		end else if (tick) begin
			next_st.bcnt = st.bcnt + 13'h1;
		end
		if (st.fsm == S_WAIT) begin
			if (!st.tim.ben) begin
				go = smp_wrap;
			end else if (bwrap && !st.bact) begin
				go = 1'b1;
				next_st.bact = 1'b1;
				next_st.grp = 7'h0;
				next_st.acc = '0;
				next_st.scnt = 13'h0;
			end else begin
				go = st.bact && smp_wrap;
			end
		end
		// Slot sequencer
		case (st.fsm)
			S_WAIT: begin
				if (go) begin
					next_st.slot = 3'h0;
					next_st.led = 1'b1;
					next_st.cnt = settle_cyc(st.tim.settle) - 10'h1;
					next_st.fsm = S_SETTLE;
				end
			end
			S_SETTLE: begin
				if (st.cnt == 10'h0) begin
					next_st.adc = 1'b1;
					next_st.fsm = S_INTEG;
				end else begin
					next_st.cnt = st.cnt - 10'h1;
				end
			end
			S_INTEG: begin
				if (i_conv.valid) begin
					next_st.led = 1'b0;
					if (grp_last) begin
						next_st.fifo.valid = 1'b1;
						next_st.fifo.slot = st.slot;
						next_st.fifo.data = ADC_W'(sum >> eff_avg);
						next_st.acc[st.slot] = '0;
					end else begin
						next_st.acc[st.slot] = sum;
					end
					if (st.slot == 3'h0 && i_conv.data[ADC_W-1 -: 8] >= st.thr && st.prox) begin
						ev[0] = 1'b1;
					end
					// walk the slot sequence
					// Past the end too, so a shrunk sequence still closes
					if (st.slot >= nslot - 3'h1) begin
						next_st.fsm = S_WAIT;
						next_st.grp = grp_last ? 7'h0 : st.grp + 7'h1;
						if (grp_last) begin
							next_st.bact = 1'b0;
						end
					end else begin
						next_st.slot = st.slot + 3'h1;
						next_st.led = 1'b1;
						next_st.cnt = settle_cyc(st.tim.settle) - 10'h1;
						next_st.fsm = S_SETTLE;
					end
				end
			end
			default: begin
				next_st.fsm = S_WAIT;
			end
		endcase
		if (st.tim.ben && lut == LUT_DIS) begin
			next_st.tim.ben = 1'b0;
			next_st.bact = 1'b0;
			ev[1] = 1'b1;
		end
		if (!st.tim.ben) begin
			next_st.bact = 1'b0;
		end
		// Register writes
		if (i_bus.wr) begin
			case (i_bus.addr)
				ADDR_EXPO: next_st.expo = ppgab_expo_s'({3'h0, i_bus.wdata[4:0]});
				ADDR_RATE: begin
					mc = max_code(i_bus.wdata[7:3] inside {[5'h06:5'h09]},
						slots_of(st.expo.nexp), st.expo.tint);
					next_st.rate = i_bus.wdata;
					if (sps_of(i_bus.wdata[7:3]) > sps_of(mc)) begin
						next_st.rate.sr = mc;
					end
				end
				ADDR_TIMING: next_st.tim = ppgab_timing_s'(i_bus.wdata & 8'he7);
				ADDR_THRESH: next_st.thr = i_bus.wdata;
				ADDR_BIAS: next_st.bias = ppgab_bias_s'(i_bus.wdata & 8'h77);
				ADDR_SPIKE: next_st.spk = i_bus.wdata;
				ADDR_ISTAT: w1c = i_bus.wdata[1:0];
				ADDR_IMASK: next_st.imask = i_bus.wdata[1:0];
				ADDR_PROX: next_st.prox = st.prox | i_bus.wdata[0];
				default: ;
			endcase
		end
		if (ev[0]) begin
			next_st.prox = 1'b0;
		end
		// Events win over a same-cycle clear
		next_st.istat = (st.istat & ~w1c) | ev;
		// Register reads, answer next cycle only
		if (i_bus.rd) begin
			case (i_bus.addr)
				ADDR_EXPO: next_st.rdata = st.expo;
				ADDR_RATE: next_st.rdata = st.rate;
				ADDR_TIMING: next_st.rdata = st.tim;
				ADDR_THRESH: next_st.rdata = st.thr;
				ADDR_BIAS: next_st.rdata = st.bias;
				ADDR_SPIKE: next_st.rdata = st.spk;
				ADDR_ISTAT: next_st.rdata = {6'h00, st.istat};
				ADDR_IMASK: next_st.rdata = {6'h00, st.imask};
				ADDR_PROX: next_st.rdata = {7'h00, st.prox};
				default: next_st.rdata = 8'h00;
			endcase
		end
		// Synchronous reset
		if (i_sys_rst) begin
			next_st = '0;
			next_st.expo = RST_EXPO;
			next_st.rate = RST_RATE;
			next_st.tim = RST_TIMING;
			next_st.spk = RST_SPIKE;
		end
	end

	// State register
	always_ff @(posedge i_sys_clk) begin
		st <= next_st;
	end

	// Outputs
	assign o_rdata = st.rdata;
	assign o_led_on = st.led;
	assign o_adc_start = st.adc;
	assign o_slot = st.slot;
	assign o_fifo = st.fifo;
	assign o_prox_mode = st.prox;
	assign o_irq = |(st.istat & st.imask);
	assign o_cfg = '{tint: st.expo.tint, filt: st.tim.filt, bias: st.bias, spike: st.spk};

	// Check helper: cycles spent settling, code latched at settle start
	always_ff @(posedge i_sys_clk) begin
		settle_hcnt <= (i_sys_rst || st.fsm != S_SETTLE) ? 10'h0 : settle_hcnt + 10'h1;
		settle_cd <= (st.fsm == S_SETTLE) ? settle_cd : st.tim.settle;
	end

	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	a_settle_len: assert property (o_adc_start |-> settle_hcnt == settle_cyc(settle_cd))
		else $error("settle delay wrong");
	a_burst_fallback: assert property (st.tim.ben && lut == LUT_DIS
		&& !(i_bus.wr && i_bus.addr == ADDR_TIMING) |=> !st.tim.ben && st.istat[1])
		else $error("burst not dropped");
	a_avg_clamp: assert property (o_fifo.valid && $past(st.tim.ben)
		|-> $past(eff_avg) <= $past(lut[2:0]))
		else $error("average above limit");
	a_push_group: assert property (o_fifo.valid |-> $past(grp_last)
		&& $past(st.fsm) == S_INTEG) else $error("push off group end");
	a_acc_cleared: assert property (o_fifo.valid |-> st.acc[o_fifo.slot] == '0)
		else $error("sum not cleared");
	a_presence_hit: assert property (st.fsm == S_INTEG && i_conv.valid && st.slot == 3'h0
		&& st.prox && i_conv.data[ADC_W-1 -: 8] >= st.thr |=> st.istat[0] && !st.prox)
		else $error("presence missed");
	a_cont_start: assert property (st.fsm == S_WAIT && !st.tim.ben && smp_wrap
		|=> st.fsm == S_SETTLE && st.slot == 3'h0) else $error("continuous start lost");
	a_burst_idle: assert property (st.fsm == S_WAIT && st.tim.ben && !st.bact && !bwrap
		|=> st.fsm == S_WAIT) else $error("burst started early");
	a_slot_order: assert property (st.fsm == S_INTEG && i_conv.valid && st.slot < nslot - 3'h1
		|=> st.slot == $past(st.slot) + 3'h1 && st.fsm == S_SETTLE) else $error("slot skipped");
	a_rate_clamp: assert property (i_bus.wr && i_bus.addr == ADDR_RATE
		|=> st.rate.sr == $past(i_bus.wdata[7:3])
		|| sps_of(st.rate.sr) < sps_of($past(i_bus.wdata[7:3]))) else $error("rate not clamped");
endmodule // ppgab_core

//--- hdl/ppgab_pkg.sv
// Purpose: shared constants, register layouts and carriers of the
//          averaging, burst and presence sequencer
// Assumes: 50 MHz system clock, 32768 Hz sampling time base
// Notes:   register offsets are byte addresses on the plain port
package ppgab_pkg;

	// Clock and time base
	localparam int SYS_CLK_HZ  = 50_000_000;
	localparam int SYS_CLK_MHZ = 50;
	localparam int SMP_CLK_HZ  = 32768;
	localparam int TICK_CYC    = SYS_CLK_HZ / SMP_CLK_HZ;
	localparam int ADC_W       = 19;
	localparam int ACC_W       = ADC_W + 7;
	localparam int SLOTS       = 6;
	// Emitter settling times in ns, indexed by code
	localparam int SETTLE_NS [4] = '{4000, 6000, 8000, 12000};

	// Register offsets
	localparam logic [7:0] ADDR_EXPO   = 8'h10;
	localparam logic [7:0] ADDR_RATE   = 8'h12;
	localparam logic [7:0] ADDR_TIMING = 8'h13;
	localparam logic [7:0] ADDR_THRESH = 8'h14;
	localparam logic [7:0] ADDR_BIAS   = 8'h15;
	localparam logic [7:0] ADDR_SPIKE  = 8'h16;
	localparam logic [7:0] ADDR_ISTAT  = 8'h17;
	localparam logic [7:0] ADDR_IMASK  = 8'h18;
	localparam logic [7:0] ADDR_PROX   = 8'h19;
	localparam logic [3:0] LUT_DIS     = 4'hf;

	// Register layouts, field positions by declaration order
	typedef struct packed {logic [2:0] rsvd; logic [2:0] nexp; logic [1:0] tint;} ppgab_expo_s;
	typedef struct packed {logic [4:0] sr; logic [2:0] avg;} ppgab_rate_s;
	typedef struct packed {
		logic [1:0] settle; logic filt; logic [1:0] rsvd; logic [1:0] brate; logic ben;
	} ppgab_timing_s;
	typedef struct packed {logic p2; logic [2:0] b2; logic p1; logic [2:0] b1;} ppgab_bias_s;
	typedef struct packed {
		logic on; logic order; logic [1:0] coeff; logic [1:0] start; logic [1:0] gain;
	} ppgab_spike_s;

	// Reset values
	localparam ppgab_expo_s   RST_EXPO   = '{rsvd: 3'h0, nexp: 3'h1, tint: 2'h0};
	localparam ppgab_rate_s   RST_RATE   = '{sr: 5'h11, avg: 3'h0};
	localparam ppgab_timing_s RST_TIMING = '{settle: 2'h1, default: '0};
	localparam ppgab_spike_s  RST_SPIKE  = '{order: 1'h1, default: '0};

	// Carriers
	typedef struct packed {logic wr; logic rd; logic [7:0] addr; logic [7:0] wdata;} ppgab_bus_s;
	typedef struct packed {logic valid; logic [ADC_W-1:0] data;} ppgab_conv_s;
	typedef struct packed {logic valid; logic [2:0] slot; logic [ADC_W-1:0] data;} ppgab_fifo_s;
	typedef struct packed {
		logic [1:0] tint; logic filt; ppgab_bias_s bias; ppgab_spike_s spike;
	} ppgab_cfg_s;
	typedef enum logic [1:0] {S_WAIT, S_SETTLE, S_INTEG} ppgab_fsm_e;

	// Sample period in time base ticks per rate code
	function automatic logic [12:0] smp_ticks(input logic [4:0] c);
		case (c)
			5'h00, 5'h06: smp_ticks = 13'h51f;
			5'h01, 5'h07: smp_ticks = 13'h28f;
			5'h02, 5'h08: smp_ticks = 13'h186;
			5'h03, 5'h09: smp_ticks = 13'h148;
			5'h04: smp_ticks = 13'h0a4;
			5'h05: smp_ticks = 13'h052;
			5'h0a: smp_ticks = 13'h1000;
			5'h0b: smp_ticks = 13'h800;
			5'h0c: smp_ticks = 13'h400;
			5'h0d: smp_ticks = 13'h200;
			5'h0e: smp_ticks = 13'h100;
			5'h0f: smp_ticks = 13'h080;
			5'h10: smp_ticks = 13'h040;
			5'h11: smp_ticks = 13'h020;
			5'h12: smp_ticks = 13'h010;
			default: smp_ticks = 13'h008;
		endcase
	endfunction

	// Burst period in ticks: 8, 32, 84, 256 Hz
	function automatic logic [12:0] burst_ticks(input logic [1:0] c);
		case (c)
			2'h0: burst_ticks = 13'h1000;
			2'h1: burst_ticks = 13'h400;
			2'h2: burst_ticks = 13'h186;
			default: burst_ticks = 13'h080;
		endcase
	endfunction
endpackage

//--- dv/ppg_average_burst_config_tb.sv
// Purpose: self-checking bench of the averaging, burst and presence block
// Assumes: the ADC answers each integration start four cycles later
// Notes:   time base divider shortened, every period scales with TD
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %0t got %0h exp %0h", $time, (g), (e)); end end

module ppg_average_burst_config_tb;
	import ppgab_pkg::*;

	localparam int TD = 32;                                  // Cycles per time base tick
	localparam logic [7:0]       THR [4] = '{8'h40, 8'h40, 8'hff, 8'hff};
	localparam logic [ADC_W-1:0] DAT [4] = '{19'h1ffff, 19'h20000, 19'h7f7ff, 19'h7ffff};

	logic             i_sys_clk = 1'b0;                      // System clock
	logic             i_sys_rst = 1'b1;                      // Synchronous reset
	ppgab_bus_s       bus       = '0;                        // Register port request
	ppgab_conv_s      conv      = '0;                        // ADC result
	logic [7:0]       rdata;                                 // Read data
	logic             led;                                   // Emitter on
	logic             adc_start;                             // Integration start
	logic [2:0]       slot;                                  // Current slot
	ppgab_fifo_s      fifo;                                  // Averaged result
	ppgab_cfg_s       cfg;                                   // Config fields
	logic             prox;                                  // Proximity mode
	logic             irq;                                   // Interrupt
	int               n_errors  = 0;
	int               cmp_count = 0;
	int               n_push    = 0;                         // Averaged results seen
	int               n_conv    = 0;                         // ADC results sent
	int               cyc       = 0;                         // Cycle counter
	int               last_cyc  = 0;                         // Cycle of last push
	int               last_slot = 0;                         // Slot of last push
	int               exp_avg   = 0;                         // Expected effective code
	int               conv_step = 1;                         // Data step per result
	int               cd        = 0;                         // ADC answer countdown
	int               s         = 0;                         // Running sum
	int               q [8][$];                              // Sent results per slot
	bit               chk_on    = 1'b0;                      // Averages judged
	bit               fire      = 1'b0;                      // Result this edge
	logic [2:0]       cslot     = '0;                        // Slot of pending result
	logic [ADC_W-1:0] conv_base = '0;                        // Base ADC value
	logic [ADC_W-1:0] conv_val  = '0;                        // Value sent

	ppgab_core #(.TICK_DIV(TD)) u_dut (
		.i_sys_clk   (i_sys_clk),
		.i_sys_rst   (i_sys_rst),
		.i_bus       (bus),
		.o_rdata     (rdata),
		.i_conv      (conv),
		.o_led_on    (led),
		.o_adc_start (adc_start),
		.o_slot      (slot),
		.o_fifo      (fifo),
		.o_cfg       (cfg),
		.o_prox_mode (prox),
		.o_irq       (irq)
	);

	// Clock at 50 MHz
	always #10 i_sys_clk = ~i_sys_clk;

	// ADC stand-in, one result four cycles after each start
	always @(posedge i_sys_clk) begin
		fire = 1'b0;
		if (adc_start === 1'b1) begin
			cd = 3;
			cslot = slot;
		end else if (cd > 0) begin
			cd--;
			fire = (cd == 0);
		end
		if (fire) begin
			conv_val = conv_base + ADC_W'(n_conv * conv_step);
			q[cslot].push_back(int'(conv_val));
			n_conv++;
		end
		conv <= '{valid: fire, data: conv_val};
	end

	// Result monitor, judges each pushed average against sent data while chk_on
	always @(posedge i_sys_clk) begin
		cyc++;
		if (fifo.valid === 1'b1) begin
			s = 0;
			foreach (q[fifo.slot][i]) s += q[fifo.slot][i];
			if (chk_on) begin
				`CHK(q[fifo.slot].size(), 1 << exp_avg)
				`CHK(fifo.data, ADC_W'(s >> exp_avg))
			end
			q[fifo.slot].delete();
			last_cyc = cyc;
			last_slot = int'(fifo.slot);
			n_push++;
		end
	end

	// One register write
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_sys_clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_sys_clk);
		bus <= '0;
		#1;
	endtask

	// One register read, data taken in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] d;
		@(posedge i_sys_clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_sys_clk);
		bus <= '0;
		#1 d = rdata;
		`CHK(d, e)
	endtask

	// Bounded wait for n results (sel) or n pushes
	task automatic wait_ev(input bit sel, input int n);
		int t;
		int k;
		t = (sel ? n_conv : n_push) + n;
		k = 0;
		while ((sel ? n_conv : n_push) < t && k < 60000) begin
			@(posedge i_sys_clk);
			k++;
		end
		`CHK((sel ? n_conv : n_push) >= t, 1'b1)
	endtask

	// Flush stale groups, then judge averages with code a
	task automatic arm(input int a, input int n);
		exp_avg = a;
		wait_ev(1'b0, n);
		chk_on = 1'b1;
	endtask

	// Spacing between two pushes
	task automatic chk_gap(input int e);
		int t0;
		wait_ev(1'b0, 1);
		t0 = last_cyc;
		wait_ev(1'b0, 1);
		`CHK(last_cyc - t0, e)
	endtask

	// Reset values, reserved bits, unmapped place, config fields
	task automatic t_regs;
		rchk(ADDR_RATE, 8'h88);
		rchk(ADDR_TIMING, 8'h40);
		rchk(ADDR_THRESH, 8'h00);
		rchk(ADDR_SPIKE, 8'h40);
		`CHK(cfg.spike, 8'h40)
		rchk(ADDR_BIAS, 8'h00);
		wr(ADDR_BIAS, 8'hff);
		rchk(ADDR_BIAS, 8'h77);
		`CHK(cfg.bias, 8'h77)
		wr(ADDR_THRESH, 8'ha5);
		rchk(ADDR_THRESH, 8'ha5);
		wr(8'h30, 8'hff);
		rchk(8'h30, 8'h00);
		for (int f = 0; f < 2; f++) begin
			wr(ADDR_TIMING, f ? 8'h20 : 8'h00);
			rchk(ADDR_TIMING, f ? 8'h20 : 8'h00);
			`CHK(cfg.filt, 1'(f))
		end
		wr(ADDR_SPIKE, 8'h80);
		rchk(ADDR_SPIKE, 8'h80);
		`CHK(cfg.spike.on, 1'b1)
	endtask

	// Emitter rise to integration start for every settle code
	task automatic t_settle;
		int n;
		logic pl;
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_TIMING, {2'(c), 6'h00});
			wait_ev(1'b1, 1);
			n = 0;
			do begin
				pl = led;
				@(posedge i_sys_clk);
				n++;
			end while (!(led === 1'b1 && pl === 1'b0) && n < 5000);
			`CHK(slot, 3'h0)
			n = 0;
			while (adc_start !== 1'b1 && n < 2000) begin
				@(posedge i_sys_clk);
				n++;
			end
			`CHK(n, SETTLE_NS[c] * SYS_CLK_MHZ / 1000)
		end
		wr(ADDR_TIMING, 8'h00);
	endtask

	// Averaging for codes 0 to 2, continuous spacing at code zero
	task automatic t_average;
		for (int a = 0; a < 3; a++) begin
			chk_on = 1'b0;
			wr(ADDR_RATE, {5'h13, 3'(a)});
			arm(a, 2);
			wait_ev(1'b0, 2);
			if (a == 0) begin
				chk_gap(TD * 8);
			end
		end
	endtask

	// Three slots in order, each averaged on its own
	task automatic t_slots;
		int k;
		chk_on = 1'b0;
		wr(ADDR_EXPO, 8'h0c);
		wr(ADDR_RATE, 8'h99);
		arm(1, 6);
		k = 0;
		while (last_slot != 2 && k < 4) begin
			wait_ev(1'b0, 1);
			k++;
		end
		for (int i = 0; i < 3; i++) begin
			wait_ev(1'b0, 1);
			`CHK(last_slot, i)
		end
		chk_on = 1'b0;
		wr(ADDR_EXPO, 8'h04);
	endtask

	// Unsupported rate stored as highest supported
	task automatic t_rate_clamp;
		wr(ADDR_EXPO, 8'h07);
		`CHK(cfg.tint, 2'h3)
		wr(ADDR_RATE, 8'h98);
		rchk(ADDR_RATE, 8'h88);
		wr(ADDR_EXPO, 8'h04);
	endtask

	// Burst at the fastest repeat, average code clamped to 2
	task automatic t_burst;
		chk_on = 1'b0;
		wr(ADDR_RATE, 8'h9d);
		wr(ADDR_TIMING, 8'h07);
		arm(2, 2);
		chk_gap(TD * 128);
		rchk(ADDR_RATE, 8'h9d);
		rchk(ADDR_TIMING, 8'h07);
		chk_on = 1'b0;
		wr(ADDR_TIMING, 8'h00);
	endtask

	// Burst that cannot fit falls back, with masked interrupt
	task automatic t_auto_off;
		wr(ADDR_IMASK, 8'h00);
		wr(ADDR_RATE, 8'h80);
		wr(ADDR_TIMING, 8'h07);
		rchk(ADDR_TIMING, 8'h06);
		rchk(ADDR_ISTAT, 8'h02);
		`CHK(irq, 1'b0)
		wr(ADDR_IMASK, 8'h02);
		`CHK(irq, 1'b1)
		wr(ADDR_ISTAT, 8'h02);
		`CHK(irq, 1'b0)
		rchk(ADDR_ISTAT, 8'h00);
		wait_ev(1'b0, 1);
		wr(ADDR_IMASK, 8'h00);
		wr(ADDR_RATE, 8'h98);
	endtask

	// Presence compare just below and at the threshold
	task automatic t_presence;
		wr(ADDR_IMASK, 8'h01);
		conv_step = 0;
		for (int i = 0; i < 4; i++) begin
			conv_base = DAT[i];
			wr(ADDR_ISTAT, 8'h01);
			wr(ADDR_THRESH, THR[i]);
			wr(ADDR_PROX, 8'h01);
			wait_ev(1'b1, 3);
			`CHK(prox, 1'(~i & 1))
			rchk(ADDR_ISTAT, {7'h00, 1'(i & 1)});
			`CHK(irq, 1'(i & 1))
		end
		wr(ADDR_IMASK, 8'h00);
	endtask

	// Counts, verdict and end of run
	task automatic give_verdict;
		$display("errors %0d compares %0d", n_errors, cmp_count);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// Watchdog against a hung sequence
	initial begin
		repeat (90000) @(posedge i_sys_clk);
		n_errors++;
		give_verdict();
	end

	// Main sequence
	initial begin
		repeat (2) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		t_regs();
		t_settle();
		t_average();
		t_slots();
		t_rate_clamp();
		t_burst();
		t_auto_off();
		t_presence();
		give_verdict();
	end
endmodule // ppg_average_burst_config_tb
